// *** common/lpdpd_pkg.sv ***
// Shared types and timing constants for the power-down sequencer
package lpdpd_pkg;

  // ****************************************
  // Core clock
  // ****************************************
  localparam logic [23:0] CORE_PERIOD_PS = 24'h00c350;

  // ****************************************
  // Delays: time in ps and clock count
  // ****************************************
  localparam logic [23:0] CMD_TO_CKE_LOW_DELAY_PS = 24'h0006d6;
  localparam logic [4:0] CMD_TO_CKE_LOW_DELAY_NCK = 5'h03;
  localparam logic [23:0] CLOCK_HOLD_AFTER_CKE_LOW_PS = 24'h001388;
  localparam logic [4:0] CLOCK_HOLD_AFTER_CKE_LOW_NCK = 5'h05;
  localparam logic [23:0] CS_SETUP_BEFORE_CKE_LOW_PS = 24'h0006d6;
  localparam logic [23:0] CS_HOLD_AFTER_CKE_LOW_PS = 24'h001388;
  localparam logic [4:0] CS_HOLD_AFTER_CKE_LOW_NCK = 5'h05;
  localparam logic [23:0] CLOCK_SETUP_BEFORE_CKE_HIGH_PS = 24'h0006d6;
  localparam logic [4:0] CLOCK_SETUP_BEFORE_CKE_HIGH_NCK = 5'h03;
  localparam logic [23:0] POWERDOWN_EXIT_DELAY_PS = 24'h001d4c;
  localparam logic [4:0] POWERDOWN_EXIT_DELAY_NCK = 5'h05;
  localparam logic [23:0] CS_SETUP_BEFORE_CKE_HIGH_PS = 24'h0006d6;
  localparam logic [23:0] CS_HOLD_AFTER_CKE_HIGH_PS = 24'h001d4c;
  localparam logic [4:0] CS_HOLD_AFTER_CKE_HIGH_NCK = 5'h05;
  localparam logic [23:0] MODE_WRITE_TO_CKE_LOW_HOLD_PS = 24'h0036b0;
  localparam logic [4:0] MODE_WRITE_TO_CKE_LOW_HOLD_NCK = 5'h0a;
  localparam logic [23:0] CALIB_START_TO_CKE_LOW_HOLD_PS = 24'h0006d6;
  localparam logic [4:0] CALIB_START_TO_CKE_LOW_HOLD_NCK = 5'h03;
  localparam logic [4:0] FIFO_WRITE_AFTER_EXIT_DELAY_NCK = 5'h03;
  localparam logic [23:0] OSC_STOP_TO_READOUT_DELAY_PS = 24'h009c40;
  localparam logic [4:0] OSC_STOP_TO_READOUT_DELAY_NCK = 5'h08;
  localparam logic [23:0] CLOCK_HOLD_AFTER_SETPOINT_ENTRY_PS = 24'h001d4c;
  localparam logic [4:0] CLOCK_HOLD_AFTER_SETPOINT_ENTRY_NCK = 5'h04;
  localparam logic [23:0] CLOCK_BEFORE_FIRST_CMD_AFTER_SETPOINT_PS = 24'h001d4c;
  localparam logic [4:0] CLOCK_BEFORE_FIRST_CMD_AFTER_SETPOINT_NCK = 5'h04;
  localparam logic [23:0] SETPOINT_SWITCH_TIME_SHORT_PS = 24'h030d40;
  localparam logic [23:0] SETPOINT_SWITCH_TIME_MIDDLE_PS = 24'h030d40;
  localparam logic [23:0] SETPOINT_SWITCH_TIME_LONG_PS = 24'h03d090;

  // ****************************************
  // Reference voltage field layout
  // ****************************************
  localparam int VREF_RANGE_BIT = 6;
  localparam int VREF_VALUE_MSB = 5;
  localparam logic [5:0] VREF_STEP_THRESH = 6'h04;

  // ****************************************
  // Gate mask bits
  // ****************************************
  localparam int GATE_FIFO_BIT = 0;
  localparam int GATE_READ_BIT = 1;

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [2:0] {
    CMD_OTHER = 3'h0,
    CMD_MODE_WRITE = 3'h1,
    CMD_CALIB_START = 3'h2,
    CMD_FIFO_WRITE = 3'h3,
    CMD_OSC_STOP = 3'h4,
    CMD_MODE_READ = 3'h5,
    CMD_SETPOINT = 3'h6
  } lpdpd_cmd_e;

  typedef enum logic [2:0] {
    ST_ACTIVE = 3'h0,
    ST_PD_HOLD = 3'h1,
    ST_PD_SLEEP = 3'h3,
    ST_EXIT_SETUP = 3'h2,
    ST_EXIT_WAIT = 3'h6,
    ST_FSP_ENTRY = 3'h7,
    ST_FSP_SWITCH = 3'h5,
    ST_FSP_EXIT = 3'h4
  } lpdpd_state_e;

  typedef struct packed {
    lpdpd_cmd_e kind;
    logic [15:0] addr;
  } lpdpd_cmd_s;

  typedef struct packed {
    logic cke;
    logic ck_run;
    logic cs_valid;
    logic cmd_valid;
    lpdpd_cmd_s cmd;
  } lpdpd_pins_s;

  localparam lpdpd_pins_s PINS_RESET = '{
    cke: 1'b1, ck_run: 1'b1, cs_valid: 1'b1, cmd_valid: 1'b0,
    cmd: '{kind: CMD_OTHER, addr: 16'h0000}};

endpackage

// *** design/lpdpd_wait_timer.sv ***
// Minimum-delay timer that honours a time and a clock count together
`timescale 1ns/1ns
module lpdpd_wait_timer (
  input wire logic core_clk_in,
  input wire logic srst_in,
  input wire logic start_in,
  input wire logic [23:0] time_ps_in,
  input wire logic [4:0] ncyc_in,
  input wire logic [15:0] tck_ps_in,
  output logic done_out
);

  logic busy_q, busy_d;
  logic [23:0] target_q, target_d;
  logic [23:0] elapsed_q, elapsed_d;
  logic [23:0] cyc_ps;
  logic [24:0] sum;

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    cyc_ps = 24'(ncyc_in) * 24'(tck_ps_in);
    sum = {1'b0, elapsed_q} + {1'b0, lpdpd_pkg::CORE_PERIOD_PS};
    busy_d = busy_q;
    target_d = target_q;
    elapsed_d = elapsed_q;
    if (start_in) begin
      target_d = (time_ps_in > cyc_ps) ? time_ps_in : cyc_ps;
      elapsed_d = 24'h000000;
      busy_d = 1'b1;
    end else if (busy_q) begin
      elapsed_d = sum[23:0];
      if (sum >= {1'b0, target_q}) begin
        busy_d = 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      busy_q <= 1'b0;
      target_q <= 24'h000000;
      elapsed_q <= 24'h000000;
    end else begin
      busy_q <= busy_d;
      target_q <= target_d;
      elapsed_q <= elapsed_d;
    end
  end

  assign done_out = !busy_q;

endmodule

// *** design/lpdpd_fsp_class.sv ***
// Set point switching time class from both reference voltage settings
`timescale 1ns/1ns
module lpdpd_fsp_class (
  input wire logic [6:0] vref_op0_in,
  input wire logic [6:0] vref_op1_in,
  output logic [23:0] switch_ps_out
);

  logic [5:0] v0, v1, diff;

  always_comb begin
    v0 = vref_op0_in[lpdpd_pkg::VREF_VALUE_MSB:0];
    v1 = vref_op1_in[lpdpd_pkg::VREF_VALUE_MSB:0];
    diff = (v0 > v1) ? (v0 - v1) : (v1 - v0);
    if (vref_op0_in[lpdpd_pkg::VREF_RANGE_BIT] !=
        vref_op1_in[lpdpd_pkg::VREF_RANGE_BIT]) begin
      switch_ps_out = lpdpd_pkg::SETPOINT_SWITCH_TIME_LONG_PS;
    end else if (diff > lpdpd_pkg::VREF_STEP_THRESH) begin
      switch_ps_out = lpdpd_pkg::SETPOINT_SWITCH_TIME_MIDDLE_PS;
    end else begin
      switch_ps_out = lpdpd_pkg::SETPOINT_SWITCH_TIME_SHORT_PS;
    end
  end

endmodule

// *** design/lpdpd_ctrl.sv ***
// Host-side power-down and set point sequencer for a low-power DRAM
`timescale 1ns/1ns
module lpdpd_ctrl (
  input wire logic core_clk_in,
  input wire logic srst_in,
  input wire logic [15:0] tck_ps_in,
  input wire logic [23:0] rcd_ps_in,
  input wire logic [6:0] vref_op0_in,
  input wire logic [6:0] vref_op1_in,
  input wire logic pd_req_in,
  input wire logic cmd_valid_in,
  input wire lpdpd_pkg::lpdpd_cmd_s cmd_in,
  output logic cmd_ready_out,
  output lpdpd_pkg::lpdpd_pins_s pins_out,
  output logic powered_down_out
);

  lpdpd_pkg::lpdpd_state_e state_q, state_d;
  lpdpd_pkg::lpdpd_cmd_e last_kind_q, last_kind_d;
  lpdpd_pkg::lpdpd_pins_s pins_q, pins_d;
  logic pd_q, pd_d;
  logic [1:0] gate_mask_q, gate_mask_d;
  logic seq_start, seq_done;
  logic gate_start, gate_done;
  logic [23:0] seq_ps, gate_ps, fsp_ps;
  logic [4:0] seq_ncyc, gate_ncyc;
  logic accept, blocked;

  function automatic logic [23:0] max_ps(
    input logic [23:0] a,
    input logic [23:0] b
  );
    return (a > b) ? a : b;
  endfunction

  function automatic logic [4:0] max_n(
    input logic [4:0] a,
    input logic [4:0] b
  );
    return (a > b) ? a : b;
  endfunction

  // ****************************************
  // Timers
  // ****************************************
  // period-driven counts
  lpdpd_wait_timer u_seq_timer (
    .core_clk_in(core_clk_in),
    .srst_in(srst_in),
    .start_in(seq_start),
    .time_ps_in(seq_ps),
    .ncyc_in(seq_ncyc),
    .tck_ps_in(tck_ps_in),
    .done_out(seq_done)
  );

  lpdpd_wait_timer u_gate_timer (
    .core_clk_in(core_clk_in),
    .srst_in(srst_in),
    .start_in(gate_start),
    .time_ps_in(gate_ps),
    .ncyc_in(gate_ncyc),
    .tck_ps_in(tck_ps_in),
    .done_out(gate_done)
  );

  lpdpd_fsp_class u_fsp_class (
    .vref_op0_in(vref_op0_in),
    .vref_op1_in(vref_op1_in),
    .switch_ps_out(fsp_ps)
  );

  // ****************************************
  // Command acceptance
  // ****************************************
  always_comb begin
    blocked = 1'b0;
    if (!gate_done) begin
      if (cmd_in.kind == lpdpd_pkg::CMD_FIFO_WRITE &&
          gate_mask_q[lpdpd_pkg::GATE_FIFO_BIT]) begin
        blocked = 1'b1;
      end
      if (cmd_in.kind == lpdpd_pkg::CMD_MODE_READ &&
          gate_mask_q[lpdpd_pkg::GATE_READ_BIT]) begin
        blocked = 1'b1;
      end
      if (cmd_in.kind == lpdpd_pkg::CMD_OSC_STOP) begin
        blocked = 1'b1;
      end
    end
  end

  assign cmd_ready_out = (state_q == lpdpd_pkg::ST_ACTIVE) &&
                         !pd_req_in && !blocked;
  assign accept = cmd_valid_in && cmd_ready_out;

  // ****************************************
  // Sequencer
  // ****************************************
  always_comb begin
    state_d = state_q;
    last_kind_d = last_kind_q;
    gate_mask_d = gate_mask_q;
    seq_start = 1'b0;
    seq_ps = 24'h000000;
    seq_ncyc = 5'h00;
    gate_start = 1'b0;
    gate_ps = 24'h000000;
    gate_ncyc = 5'h00;
    pins_d = pins_q;
    pins_d.cmd_valid = 1'b0;
    case (state_q)
      lpdpd_pkg::ST_ACTIVE: begin
        if (pd_req_in && seq_done && gate_done) begin
          state_d = lpdpd_pkg::ST_PD_HOLD;
          seq_start = 1'b1;
          seq_ps = max_ps(lpdpd_pkg::CLOCK_HOLD_AFTER_CKE_LOW_PS,
                          lpdpd_pkg::CS_HOLD_AFTER_CKE_LOW_PS);
          seq_ncyc = max_n(lpdpd_pkg::CLOCK_HOLD_AFTER_CKE_LOW_NCK,
                           lpdpd_pkg::CS_HOLD_AFTER_CKE_LOW_NCK);
          if (last_kind_q == lpdpd_pkg::CMD_MODE_WRITE) begin
            seq_ps = max_ps(seq_ps, lpdpd_pkg::MODE_WRITE_TO_CKE_LOW_HOLD_PS);
            seq_ncyc = max_n(seq_ncyc, lpdpd_pkg::MODE_WRITE_TO_CKE_LOW_HOLD_NCK);
          end
          if (last_kind_q == lpdpd_pkg::CMD_CALIB_START) begin
            seq_ps = max_ps(seq_ps, lpdpd_pkg::CALIB_START_TO_CKE_LOW_HOLD_PS);
            seq_ncyc = max_n(seq_ncyc, lpdpd_pkg::CALIB_START_TO_CKE_LOW_HOLD_NCK);
          end
        end else if (accept) begin
          pins_d.cmd_valid = 1'b1;
          pins_d.cmd = cmd_in;
          last_kind_d = cmd_in.kind;
          seq_start = 1'b1;
          seq_ps = max_ps(lpdpd_pkg::CMD_TO_CKE_LOW_DELAY_PS,
                          lpdpd_pkg::CS_SETUP_BEFORE_CKE_LOW_PS);
          seq_ncyc = lpdpd_pkg::CMD_TO_CKE_LOW_DELAY_NCK;
          if (cmd_in.kind == lpdpd_pkg::CMD_SETPOINT) begin
            state_d = lpdpd_pkg::ST_FSP_ENTRY;
            seq_ps = lpdpd_pkg::CLOCK_HOLD_AFTER_SETPOINT_ENTRY_PS;
            seq_ncyc = lpdpd_pkg::CLOCK_HOLD_AFTER_SETPOINT_ENTRY_NCK;
          end
          if (cmd_in.kind == lpdpd_pkg::CMD_OSC_STOP) begin
            gate_start = 1'b1;
            gate_ps = lpdpd_pkg::OSC_STOP_TO_READOUT_DELAY_PS;
            gate_ncyc = lpdpd_pkg::OSC_STOP_TO_READOUT_DELAY_NCK;
            gate_mask_d = 2'h0;
            gate_mask_d[lpdpd_pkg::GATE_READ_BIT] = 1'b1;
          end
        end
      end
      lpdpd_pkg::ST_PD_HOLD: begin
        if (seq_done) begin
          state_d = lpdpd_pkg::ST_PD_SLEEP;
        end
      end
      lpdpd_pkg::ST_PD_SLEEP: begin
        if (!pd_req_in) begin
          state_d = lpdpd_pkg::ST_EXIT_SETUP;
          seq_start = 1'b1;
          seq_ps = max_ps(lpdpd_pkg::CLOCK_SETUP_BEFORE_CKE_HIGH_PS,
                          lpdpd_pkg::CS_SETUP_BEFORE_CKE_HIGH_PS);
          seq_ncyc = lpdpd_pkg::CLOCK_SETUP_BEFORE_CKE_HIGH_NCK;
        end
      end
      lpdpd_pkg::ST_EXIT_SETUP: begin
        if (seq_done) begin
          state_d = lpdpd_pkg::ST_EXIT_WAIT;
          seq_start = 1'b1;
          seq_ps = max_ps(lpdpd_pkg::POWERDOWN_EXIT_DELAY_PS,
                          lpdpd_pkg::CS_HOLD_AFTER_CKE_HIGH_PS);
          seq_ncyc = max_n(lpdpd_pkg::POWERDOWN_EXIT_DELAY_NCK,
                           lpdpd_pkg::CS_HOLD_AFTER_CKE_HIGH_NCK);
        end
      end
      lpdpd_pkg::ST_EXIT_WAIT: begin
        if (seq_done) begin
          state_d = lpdpd_pkg::ST_ACTIVE;
          gate_start = 1'b1;
          gate_ps = rcd_ps_in +
                    24'(lpdpd_pkg::FIFO_WRITE_AFTER_EXIT_DELAY_NCK) * 24'(tck_ps_in);
          gate_mask_d = 2'h0;
          gate_mask_d[lpdpd_pkg::GATE_FIFO_BIT] = 1'b1;
        end
      end
      lpdpd_pkg::ST_FSP_ENTRY: begin
        if (seq_done) begin
          state_d = lpdpd_pkg::ST_FSP_SWITCH;
          seq_start = 1'b1;
          seq_ps = fsp_ps;
        end
      end
      lpdpd_pkg::ST_FSP_SWITCH: begin
        if (seq_done) begin
          state_d = lpdpd_pkg::ST_FSP_EXIT;
          seq_start = 1'b1;
          seq_ps = lpdpd_pkg::CLOCK_BEFORE_FIRST_CMD_AFTER_SETPOINT_PS;
          seq_ncyc = lpdpd_pkg::CLOCK_BEFORE_FIRST_CMD_AFTER_SETPOINT_NCK;
        end
      end
      lpdpd_pkg::ST_FSP_EXIT: begin
        if (seq_done) begin
          state_d = lpdpd_pkg::ST_ACTIVE;
        end
      end
      default: begin
        state_d = lpdpd_pkg::ST_ACTIVE;
      end
    endcase
    pins_d.cke = !(state_d inside {lpdpd_pkg::ST_PD_HOLD,
                                   lpdpd_pkg::ST_PD_SLEEP,
                                   lpdpd_pkg::ST_EXIT_SETUP});
    pins_d.ck_run = !(state_d inside {lpdpd_pkg::ST_PD_SLEEP,
                                      lpdpd_pkg::ST_FSP_SWITCH});
    pins_d.cs_valid = (state_d != lpdpd_pkg::ST_PD_SLEEP);
    pd_d = (state_d == lpdpd_pkg::ST_PD_SLEEP);
  end

  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      state_q <= lpdpd_pkg::ST_ACTIVE;
      last_kind_q <= lpdpd_pkg::CMD_OTHER;
      gate_mask_q <= 2'h0;
      pins_q <= lpdpd_pkg::PINS_RESET;
      pd_q <= 1'b0;
    end else begin
      state_q <= state_d;
      last_kind_q <= last_kind_d;
      gate_mask_q <= gate_mask_d;
      pins_q <= pins_d;
      pd_q <= pd_d;
    end
  end

  assign pins_out = pins_q;
  assign powered_down_out = pd_q;

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge core_clk_in);
  endclocking
  default disable iff (srst_in);

  property p_cmd_to_cke_low;
    $fell(pins_q.cke) |-> !$past(pins_q.cmd_valid) && $past(seq_done);
  endproperty
  a_cmd_to_cke_low: assert property (p_cmd_to_cke_low)
    else $error("CKE fell too soon after command");

  property p_clock_after_low;
    $fell(pins_q.cke) |-> pins_q.ck_run && pins_q.cs_valid;
  endproperty
  a_clock_after_low: assert property (p_clock_after_low)
    else $error("Clock or CS dropped with CKE");

  property p_cs_before_low;
    $fell(pins_q.cke) |-> $past(pins_q.cs_valid, 1) && $past(pins_q.cs_valid, 2);
  endproperty
  a_cs_before_low: assert property (p_cs_before_low)
    else $error("CS not valid before CKE low");

  property p_clock_before_high;
    $rose(pins_q.cke) |-> $past(pins_q.ck_run, 1) && $past(pins_q.ck_run, 2) &&
      $past(pins_q.cs_valid, 1) && $past(pins_q.cs_valid, 2);
  endproperty
  a_clock_before_high: assert property (p_clock_before_high)
    else $error("Clock or CS not valid before CKE high");

  property p_no_cmd_after_exit;
    $rose(pins_q.cke) |-> !pins_q.cmd_valid [*3];
  endproperty
  a_no_cmd_after_exit: assert property (p_no_cmd_after_exit)
    else $error("Command during exit delay");

  property p_cs_after_high;
    $rose(pins_q.cke) |-> (pins_q.cs_valid && pins_q.cke) [*3];
  endproperty
  a_cs_after_high: assert property (p_cs_after_high)
    else $error("CS or CKE dropped after exit");

  property p_mode_write_hold;
    (state_q == lpdpd_pkg::ST_PD_HOLD &&
     last_kind_q == lpdpd_pkg::CMD_MODE_WRITE) |-> pins_q.ck_run && pins_q.cs_valid;
  endproperty
  a_mode_write_hold: assert property (p_mode_write_hold)
    else $error("Clock or CS lost in hold after mode write");

  property p_wait_not_done;
    (state_q != lpdpd_pkg::ST_ACTIVE && state_q != lpdpd_pkg::ST_PD_SLEEP &&
     !seq_done) |=> $stable(state_q);
  endproperty
  a_wait_not_done: assert property (p_wait_not_done)
    else $error("State left before delay expired");

  property p_fifo_gate;
    (accept && cmd_in.kind == lpdpd_pkg::CMD_FIFO_WRITE) |->
      gate_done || !gate_mask_q[lpdpd_pkg::GATE_FIFO_BIT];
  endproperty
  a_fifo_gate: assert property (p_fifo_gate)
    else $error("FIFO write before exit gate expired");

  property p_osc_readout;
    (pins_q.cmd_valid && pins_q.cmd.kind == lpdpd_pkg::CMD_OSC_STOP) |=>
      !(pins_q.cmd_valid && pins_q.cmd.kind == lpdpd_pkg::CMD_MODE_READ);
  endproperty
  a_osc_readout: assert property (p_osc_readout)
    else $error("Readout too soon after oscillator stop");

  property p_fsp_entry_clock;
    state_q == lpdpd_pkg::ST_FSP_ENTRY |-> pins_q.ck_run;
  endproperty
  a_fsp_entry_clock: assert property (p_fsp_entry_clock)
    else $error("Clock stopped at set point entry");

  property p_fsp_exit_clock;
    state_q == lpdpd_pkg::ST_FSP_EXIT |-> pins_q.ck_run && !pins_q.cmd_valid;
  endproperty
  a_fsp_exit_clock: assert property (p_fsp_exit_clock)
    else $error("Command or no clock before set point exit");

  c_pd_cycle: cover property ($fell(pins_q.cke) ##[1:200] $rose(pins_q.cke));
  c_fsp_done: cover property (state_q == lpdpd_pkg::ST_FSP_EXIT ##1
                              state_q == lpdpd_pkg::ST_ACTIVE);
  c_fifo_block: cover property (cmd_valid_in && !cmd_ready_out &&
                                cmd_in.kind == lpdpd_pkg::CMD_FIFO_WRITE);

endmodule

// *** sim/lpdpd_dram_model.sv ***
// Device-side model that watches the sequencer pins and counts timing faults
`timescale 1ns/1ns
module lpdpd_dram_model (
  input wire logic core_clk_in,
  input wire logic srst_in,
  input wire logic [15:0] tck_ps_in,
  input wire logic [23:0] rcd_ps_in,
  input wire logic [6:0] vref_op0_in,
  input wire logic [6:0] vref_op1_in,
  input wire lpdpd_pkg::lpdpd_pins_s pins_in,
  output logic strobe_out,
  output logic [7:0] viol_out
);
  lpdpd_pkg::lpdpd_pins_s q;
  lpdpd_pkg::lpdpd_cmd_e last;
  int cc, cl, ch, kh, kl, co, xp;
  logic mw;

  function automatic bit ok(input int cyc, input int ps, input int n);
    return (cyc * 50000 >= ps) && (cyc * 50000 >= n * int'(tck_ps_in));
  endfunction

  task automatic need(input bit c);
    if (!c) viol_out = viol_out + 8'h01;
  endtask

  assign strobe_out = pins_in.cmd_valid && (pins_in.cmd.kind == lpdpd_pkg::CMD_MODE_WRITE);

  always @(posedge core_clk_in) begin
    if (srst_in) begin
      q = lpdpd_pkg::PINS_RESET;
      last = lpdpd_pkg::CMD_OTHER;
      viol_out = 8'h00;
      cc = 1000; cl = 1000; ch = 1000; kh = 1000; kl = 0; co = 1000;
    end else begin
      cc++; cl++; ch++; kh++; kl++; co++;
      mw = (last == lpdpd_pkg::CMD_MODE_WRITE);
      if (q.cke && !pins_in.cke) begin
        need(ok(cc, 1750, 3) && q.cs_valid);
        cl = 0;
      end
      if (!q.cke && pins_in.cke) begin
        need(pins_in.ck_run && ok(kh, 1750, 3) && q.cs_valid);
        ch = 0;
      end
      if (q.ck_run && !pins_in.ck_run) begin
        kl = 0;
        if (!pins_in.cke) need(mw ? ok(cl, 14000, 10) : ok(cl, 5000, 5));
        else need(ok(cc, 7500, 4));
      end
      if (q.cs_valid && !pins_in.cs_valid)
        need((mw ? ok(cl, 14000, 10) : ok(cl, 5000, 5)) && ok(ch, 7500, 5));
      if (!q.ck_run && pins_in.ck_run) begin
        if (pins_in.cke) need(kl * 50000 >= (vref_op0_in[6] != vref_op1_in[6] ? 250000 : 200000));
        kh = 0;
      end
      if (pins_in.cmd_valid) begin
        need(ok(ch, 7500, 5) && ok(kh, 7500, 4) && pins_in.cke && pins_in.ck_run);
        xp = 5 * int'(tck_ps_in);
        if (xp < 7500) xp = 7500;
        if (pins_in.cmd.kind == lpdpd_pkg::CMD_FIFO_WRITE)
          need(ch * 50000 >= xp + int'(rcd_ps_in) + 3 * int'(tck_ps_in));
        if (pins_in.cmd.kind == lpdpd_pkg::CMD_MODE_READ) need(ok(co, 40000, 8));
        if (pins_in.cmd.kind == lpdpd_pkg::CMD_OSC_STOP) co = 0;
        last = pins_in.cmd.kind;
        cc = 0;
      end
      q = pins_in;
    end
  end
endmodule

// *** sim/test_lpdpd_ctrl.sv ***
// Self-checking bench for the power-down and set point sequencer
`timescale 1ns/1ns
module test_lpdpd_ctrl;
  logic core_clk_in = 1'b0;
  logic srst_in = 1'b1;
  logic [15:0] tck_ps_in = 16'h7530;
  logic [23:0] rcd_ps_in = 24'h00c350;
  logic [6:0] vref_op0_in = 7'h0a;
  logic [6:0] vref_op1_in = 7'h0a;
  logic pd_req_in = 1'b0;
  logic cmd_valid_in = 1'b0;
  lpdpd_pkg::lpdpd_cmd_s cmd_in = '{kind: lpdpd_pkg::CMD_OTHER, addr: 16'h0000};
  logic cmd_ready_out;
  lpdpd_pkg::lpdpd_pins_s pins_out;
  logic powered_down_out;
  logic [7:0] viol;
  int n_fail = 0;
  int checked = 0;
  lpdpd_pkg::lpdpd_cmd_e ks[3] = '{lpdpd_pkg::CMD_OTHER, lpdpd_pkg::CMD_MODE_WRITE,
    lpdpd_pkg::CMD_CALIB_START};

  always #25 core_clk_in = ~core_clk_in;

  lpdpd_ctrl DUT (.core_clk_in(core_clk_in), .srst_in(srst_in), .tck_ps_in(tck_ps_in),
    .rcd_ps_in(rcd_ps_in), .vref_op0_in(vref_op0_in), .vref_op1_in(vref_op1_in),
    .pd_req_in(pd_req_in), .cmd_valid_in(cmd_valid_in), .cmd_in(cmd_in),
    .cmd_ready_out(cmd_ready_out), .pins_out(pins_out), .powered_down_out(powered_down_out));

  lpdpd_dram_model dram (.core_clk_in(core_clk_in), .srst_in(srst_in), .tck_ps_in(tck_ps_in),
    .rcd_ps_in(rcd_ps_in), .vref_op0_in(vref_op0_in), .vref_op1_in(vref_op1_in),
    .pins_in(pins_out), .strobe_out(), .viol_out(viol));

  // ****************************************
  // Helpers
  // ****************************************
  task automatic step();
    @(posedge core_clk_in);
    #2;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic report_and_stop();
    if (n_fail == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic send(input lpdpd_pkg::lpdpd_cmd_e k, input logic [15:0] a, input bit gated);
    int i;
    cmd_in = '{kind: k, addr: a};
    cmd_valid_in = 1'b1;
    #1;
    if (gated) chk("gated ready", 0, cmd_ready_out);
    for (i = 0; i < 400 && cmd_ready_out !== 1'b1; i++) step();
    chk("command ready", 1, cmd_ready_out);
    step();
    cmd_valid_in = 1'b0;
    chk("command pulse", 1, pins_out.cmd_valid);
    chk("command kind", k, pins_out.cmd.kind);
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic pd_cycle(input lpdpd_pkg::lpdpd_cmd_e k, input logic [15:0] t);
    int i;
    tck_ps_in = t;
    send(k, 16'h0012, 1'b0);
    pd_req_in = 1'b1;
    step();
    chk("command pulse end", 0, pins_out.cmd_valid);
    if (3 * int'(t) > 50000) begin
      step();
      chk("cke after command", 1, pins_out.cke);
    end
    for (i = 0; i < 400 && powered_down_out !== 1'b1; i++) step();
    chk("powered down", 1, powered_down_out);
    chk("cke asleep", 0, pins_out.cke);
    chk("clock asleep", 0, pins_out.ck_run);
    chk("ready asleep", 0, cmd_ready_out);
    repeat (3) step();
    pd_req_in = 1'b0;
    for (i = 0; i < 400 && cmd_ready_out !== 1'b1; i++) step();
    chk("cke awake", 1, pins_out.cke);
    chk("powered up", 0, powered_down_out);
    chk("pin timing", 0, viol);
  endtask

  task automatic fsp(input logic [6:0] a, input logic [6:0] b, input int e);
    int i;
    int n;
    vref_op0_in = a;
    vref_op1_in = b;
    n = 0;
    send(lpdpd_pkg::CMD_SETPOINT, 16'h0000, 1'b0);
    for (i = 0; i < 400 && cmd_ready_out !== 1'b1; i++) begin
      step();
      if (pins_out.ck_run === 1'b0) n++;
    end
    chk("clock stop cycles", e, n);
    send(lpdpd_pkg::CMD_OTHER, 16'h0001, 1'b0);
    step();
    chk("switch timing", 0, viol);
  endtask

  initial begin
    repeat (5000) @(posedge core_clk_in);
    n_fail++;
    report_and_stop();
  end

  initial begin
    repeat (20) step();
    srst_in = 1'b0;
    chk("reset pins", lpdpd_pkg::PINS_RESET, pins_out);
    chk("reset flag", 0, powered_down_out);
    chk("reset ready", 1, cmd_ready_out);
    foreach (ks[j]) begin
      pd_cycle(ks[j], 16'h7530);
      pd_cycle(ks[j], 16'h03e8);
    end
    pd_cycle(lpdpd_pkg::CMD_OTHER, 16'h7530);
    send(lpdpd_pkg::CMD_FIFO_WRITE, 16'h0000, 1'b1);
    step();
    chk("fifo timing", 0, viol);
    send(lpdpd_pkg::CMD_OSC_STOP, 16'h0000, 1'b0);
    send(lpdpd_pkg::CMD_MODE_READ, 16'h0000, 1'b1);
    step();
    chk("readout timing", 0, viol);
    // Stop spans switch time in 50 ns cycles plus one decision cycle
    fsp(7'h0a, 7'h0c, 5);
    fsp(7'h0a, 7'h14, 5);
    fsp(7'h4a, 7'h0a, 6);
    report_and_stop();
  end
endmodule
